// ---- hw/mcbm_pkg.sv ----
// constants, carriers and states shared by the collision/backoff engine and its buffer
// assumes one 40 MHz core clock and a synchronous active-high reset
package mcbm_pkg;

	// ****************************************
	// clocking
	// ****************************************
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned REF_HZ = 20_000_000;
	localparam int unsigned REF_DIV = 2;
	localparam int unsigned BIT_HZ = REF_HZ / REF_DIV;
	localparam int unsigned CYC_PER_REF = CLK_HZ / REF_HZ;
	localparam int unsigned CYC_PER_BIT = CLK_HZ / BIT_HZ;
	localparam int unsigned BIT_NS = 1_000_000_000 / BIT_HZ;

	// ****************************************
	// frame timing, in bit times
	// ****************************************
	localparam int unsigned PREAMBLE_BITS = 64;
	localparam int unsigned DELIM_FIRST_ONE = 62;
	localparam int unsigned JAM_BITS = 32;
	localparam int unsigned SLOT_BITS = 512;
	localparam int unsigned MAX_ATTEMPTS = 16;
	localparam int unsigned BACKOFF_LIMIT = 10;
	localparam int unsigned GAP_NS = 9600;
	localparam int unsigned GAP_BITS = (GAP_NS + BIT_NS - 1) / BIT_NS;
	localparam logic [6:0] PRE_LAST = 7'(PREAMBLE_BITS - 1);
	localparam logic [6:0] DELIM_ONE = 7'(DELIM_FIRST_ONE);
	localparam logic [6:0] JAM_LAST = 7'(JAM_BITS - 1);
	localparam logic [9:0] SLOT_CNT = 10'(SLOT_BITS);
	localparam logic [8:0] SLOT_LAST = 9'(SLOT_BITS - 1);
	localparam logic [6:0] GAP_CNT = 7'(GAP_BITS);
	localparam logic [4:0] K_LIMIT = 5'(BACKOFF_LIMIT);
	localparam logic [2:0] BYTE_LAST = 3'h7;

	// ****************************************
	// receive side
	// ****************************************
	localparam int unsigned RX_HOLD_BITS = 2;
	localparam logic [3:0] RX_HOLD_CYC = 4'(RX_HOLD_BITS * CYC_PER_BIT);
	localparam logic [2:0] RX_MIN_PULSE = 3'h2;
	localparam logic [3:0] LOCK_PATTERN = 4'ha;

	// ****************************************
	// generator and buffer
	// ****************************************
	localparam logic [15:0] LFSR_SEED = 16'hace1;
	localparam logic [15:0] LFSR_TAPS = 16'hb400;
	localparam int unsigned BUF_ENTRIES = 2;

	typedef struct packed {
		logic [7:0] data;
		logic last;
	} mcbm_byte_s;

	typedef struct packed {
		logic done;
		logic one_retry;
		logic multi_retry;
		logic retry_failure_flag;
		logic late_collision_flag;
	} mcbm_status_s;

	typedef enum logic [2:0] {
		ST_DEFER,
		ST_PRE,
		ST_DATA,
		ST_JAM,
		ST_BACKOFF
	} mcbm_state_e;

endpackage : mcbm_pkg

// ---- hw/mcbm_buf.sv ----
// small synchronous fifo in the transmit byte path
// assumes the filling and draining sides share the core clock
module mcbm_buf #(
	parameter int unsigned WIDTH = 9,
	parameter int unsigned DEPTH = 2
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clr,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	import mcbm_pkg::*;

	localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
		$error("mcbm_buf depth must be a power of two, at least two");

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr_reg;
	logic [AW:0] rd_ptr_reg;
	logic push;
	logic pop;

	assign in_ready = (wr_ptr_reg - rd_ptr_reg) != (AW + 1)'(DEPTH);
	assign out_valid = wr_ptr_reg != rd_ptr_reg;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rd_ptr_reg[AW-1:0]];

	always_ff @(posedge core_clk) begin
		if (push)
			mem[wr_ptr_reg[AW-1:0]] <= in_data;
	end

	// clear drops everything, including a word pushed in the same cycle
	always_ff @(posedge core_clk) begin
		if (rst || clr) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
		end
	end

endmodule : mcbm_buf

// ---- hw/mcbm_top.sv ----
// transmit collision handling, backoff and the digital manchester codec
// assumes col_pin and diff_rx_inputs are asynchronous levels from the analog front end
module mcbm_top #(
	parameter int unsigned MAX_TRIES = mcbm_pkg::MAX_ATTEMPTS,
	parameter int unsigned BUF_DEPTH = mcbm_pkg::BUF_ENTRIES
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire mcbm_pkg::mcbm_byte_s tx_in,
	input wire logic tx_in_valid,
	output logic tx_in_ready,
	output logic frame_rewind,
	output logic frame_flush,
	output mcbm_pkg::mcbm_status_s tx_status,
	input wire logic disable_retry_bit,
	input wire logic tx_idle_select,
	input wire logic alt_backoff_mode,
	input wire logic col_pin,
	input wire logic diff_rx_inputs,
	output logic tx_pos,
	output logic tx_neg,
	output logic internal_rx_carrier,
	output logic rx_clock_locked,
	output logic rx_bit,
	output logic rx_bit_valid
);
	import mcbm_pkg::*;

	if (MAX_TRIES < 2 || MAX_TRIES > 16)
		$error("mcbm_top attempt limit must lie between 2 and 16");
	if (CYC_PER_REF != 2 || REF_DIV != 2)
		$error("mcbm_top divider needs two core cycles per reference tick");

	localparam logic [3:0] TRY_LAST = 4'(MAX_TRIES - 1);

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic pre_bit(input logic [6:0] idx);
		pre_bit = (idx >= DELIM_ONE) | ~idx[0];
	endfunction : pre_bit

	function automatic logic [9:0] backoff_mask(input logic [4:0] n);
		logic [4:0] k;
		k = (n > K_LIMIT) ? K_LIMIT : n;
		backoff_mask = 10'((11'h1 << k) - 11'h1);
	endfunction : backoff_mask

	// ****************************************
	// declarations
	// ****************************************
	logic ref_cnt_reg;
	logic ref_en;
	logic tx_clk_reg;
	logic bit_en;
	logic col_s1_reg;
	logic col_s2_reg;
	logic rx_s1_reg;
	logic rx_s2_reg;
	logic rx_s3_reg;
	mcbm_state_e state_reg;
	logic [6:0] bit_cnt_reg;
	logic [9:0] data_cnt_reg;
	logic [2:0] bidx_reg;
	logic [7:0] sh_reg;
	logic cur_last_reg;
	logic col_pend_reg;
	logic late_reg;
	logic [3:0] tries_reg;
	logic [9:0] backoff_left_reg;
	logic [8:0] slot_cnt_reg;
	logic [6:0] gap_cnt_reg;
	logic [15:0] lfsr_reg;
	logic internal_tx_enable;
	logic internal_tx_serial_data;
	logic tx_en_q_reg;
	logic tx_dat_q_reg;
	logic col_event;
	logic collided;
	logic gap_done;
	logic buf_clr;
	logic buf_in_ready;
	logic buf_pop;
	logic buf_valid;
	mcbm_byte_s buf_out;
	mcbm_status_s status_reg;
	logic rewind_reg;
	logic flush_reg;
	logic [3:0] rx_hold_reg;
	logic [2:0] rx_run_reg;
	logic [3:0] rx_shift_reg;
	logic rx_edge;
	logic enc_en_ahead;
	logic enc_dat_ahead;
	logic enc_half_ahead;

	// ****************************************
	// clock divider
	// ****************************************
	// 20 MHz reference tick, then divided by two into the bit clock
	assign ref_en = ref_cnt_reg;
	assign bit_en = ref_en && tx_clk_reg;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			ref_cnt_reg <= 1'b0;
			tx_clk_reg <= 1'b0;
		end else begin
			ref_cnt_reg <= ~ref_cnt_reg;
			if (ref_en)
				tx_clk_reg <= ~tx_clk_reg;
		end
	end

	// ****************************************
	// input synchronisers
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (rst) begin
			col_s1_reg <= 1'b0;
			col_s2_reg <= 1'b0;
			rx_s1_reg <= 1'b0;
			rx_s2_reg <= 1'b0;
			rx_s3_reg <= 1'b0;
		end else begin
			col_s1_reg <= col_pin;
			col_s2_reg <= col_s1_reg;
			rx_s1_reg <= diff_rx_inputs;
			rx_s2_reg <= rx_s1_reg;
			rx_s3_reg <= rx_s2_reg;
		end
	end

	// only a collision while our own signal is on the wire counts
	assign col_event = col_s2_reg && tx_en_q_reg;
	assign collided = col_pend_reg || col_event;

	// ****************************************
	// transmit byte buffer
	// ****************************************
	// ready drops during the clear so no word of the old pass survives it
	assign buf_clr = rewind_reg || flush_reg;
	assign tx_in_ready = buf_in_ready && !buf_clr;
	assign buf_pop = bit_en && buf_valid && (
		(state_reg == ST_PRE && bit_cnt_reg == PRE_LAST && !collided) ||
		(state_reg == ST_DATA && !collided && bidx_reg == BYTE_LAST && !cur_last_reg));

	mcbm_buf #(
		.WIDTH($bits(mcbm_byte_s)),
		.DEPTH(BUF_DEPTH)
	) u_buf (
		.core_clk(core_clk),
		.rst(rst),
		.clr(buf_clr),
		.in_data(tx_in),
		.in_valid(tx_in_valid && !buf_clr),
		.in_ready(buf_in_ready),
		.out_data(buf_out),
		.out_valid(buf_valid),
		.out_ready(buf_pop)
	);

	// ****************************************
	// random source
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (rst)
			lfsr_reg <= LFSR_SEED;
		else
			lfsr_reg <= {1'b0, lfsr_reg[15:1]} ^ (lfsr_reg[0] ? LFSR_TAPS : 16'h0000);
	end

	// ****************************************
	// collision latch
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (rst || (state_reg != ST_PRE && state_reg != ST_DATA))
			col_pend_reg <= 1'b0;
		else if (col_event)
			col_pend_reg <= 1'b1;
	end

	// ****************************************
	// interpacket gap
	// ****************************************
	assign gap_done = gap_cnt_reg == GAP_CNT;

	always_ff @(posedge core_clk) begin
		if (rst || internal_tx_enable || tx_en_q_reg)
			gap_cnt_reg <= '0;
		else if (bit_en) begin
			if (internal_rx_carrier) begin
				if (!alt_backoff_mode)
					gap_cnt_reg <= '0;
			end else if (!gap_done)
				gap_cnt_reg <= gap_cnt_reg + 7'h01;
		end
	end

	// ****************************************
	// transmit sequencer
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_reg <= ST_DEFER;
			bit_cnt_reg <= '0;
			data_cnt_reg <= '0;
			bidx_reg <= '0;
			sh_reg <= '0;
			cur_last_reg <= 1'b0;
			late_reg <= 1'b0;
			tries_reg <= '0;
			backoff_left_reg <= '0;
			slot_cnt_reg <= '0;
			internal_tx_enable <= 1'b0;
			internal_tx_serial_data <= 1'b0;
			status_reg <= '0;
			rewind_reg <= 1'b0;
			flush_reg <= 1'b0;
		end else begin
			status_reg <= '0;
			rewind_reg <= 1'b0;
			flush_reg <= 1'b0;
			if (bit_en) begin
				case (state_reg)
					ST_DEFER: begin
						internal_tx_enable <= 1'b0;
						internal_tx_serial_data <= 1'b0;
						if (gap_done && !internal_rx_carrier && buf_valid) begin
							state_reg <= ST_PRE;
							bit_cnt_reg <= '0;
							data_cnt_reg <= '0;
							internal_tx_enable <= 1'b1;
							internal_tx_serial_data <= pre_bit(7'h00);
						end
					end
					ST_PRE: begin
						if (bit_cnt_reg == PRE_LAST) begin
							if (collided) begin
								state_reg <= ST_JAM;
								late_reg <= 1'b0;
								bit_cnt_reg <= '0;
								internal_tx_serial_data <= 1'b0;
							end else begin
								state_reg <= ST_DATA;
								sh_reg <= buf_out.data;
								cur_last_reg <= buf_out.last;
								bidx_reg <= '0;
								internal_tx_serial_data <= buf_out.data[0];
							end
						end else begin
							bit_cnt_reg <= bit_cnt_reg + 7'h01;
							internal_tx_serial_data <= pre_bit(bit_cnt_reg + 7'h01);
						end
					end
					ST_DATA: begin
						if (collided) begin
							state_reg <= ST_JAM;
							late_reg <= data_cnt_reg >= SLOT_CNT;
							bit_cnt_reg <= '0;
							internal_tx_serial_data <= 1'b0;
						end else begin
							if (data_cnt_reg != SLOT_CNT)
								data_cnt_reg <= data_cnt_reg + 10'h001;
							if (bidx_reg != BYTE_LAST) begin
								bidx_reg <= bidx_reg + 3'h1;
								internal_tx_serial_data <= sh_reg[bidx_reg + 3'h1];
							end else if (cur_last_reg || !buf_valid) begin
								// end of frame, or underrun ends it early
								state_reg <= ST_DEFER;
								internal_tx_enable <= 1'b0;
								internal_tx_serial_data <= 1'b0;
								status_reg.done <= 1'b1;
								status_reg.one_retry <= tries_reg == 4'h1;
								status_reg.multi_retry <= tries_reg > 4'h1;
								tries_reg <= '0;
							end else begin
								sh_reg <= buf_out.data;
								cur_last_reg <= buf_out.last;
								bidx_reg <= '0;
								internal_tx_serial_data <= buf_out.data[0];
							end
						end
					end
					ST_JAM: begin
						internal_tx_serial_data <= 1'b0;
						if (bit_cnt_reg != JAM_LAST)
							bit_cnt_reg <= bit_cnt_reg + 7'h01;
						else begin
							internal_tx_enable <= 1'b0;
							if (late_reg) begin
								state_reg <= ST_DEFER;
								status_reg.done <= 1'b1;
								status_reg.late_collision_flag <= 1'b1;
								flush_reg <= 1'b1;
								tries_reg <= '0;
							end else if (disable_retry_bit || tries_reg == TRY_LAST) begin
								state_reg <= ST_DEFER;
								status_reg.done <= 1'b1;
								status_reg.retry_failure_flag <= 1'b1;
								flush_reg <= 1'b1;
								tries_reg <= '0;
							end else begin
								state_reg <= ST_BACKOFF;
								tries_reg <= tries_reg + 4'h1;
								backoff_left_reg <= lfsr_reg[9:0] &
									backoff_mask({1'b0, tries_reg} + 5'h01);
								slot_cnt_reg <= '0;
								rewind_reg <= 1'b1;
							end
						end
					end
					ST_BACKOFF: begin
						if (!(alt_backoff_mode && internal_rx_carrier)) begin
							if (backoff_left_reg == 10'h000)
								state_reg <= ST_DEFER;
							else if (slot_cnt_reg == SLOT_LAST) begin
								slot_cnt_reg <= '0;
								backoff_left_reg <= backoff_left_reg - 10'h001;
							end else
								slot_cnt_reg <= slot_cnt_reg + 9'h001;
						end
					end
					default: state_reg <= ST_DEFER;
				endcase
			end
		end
	end

	assign tx_status = status_reg;
	assign frame_rewind = rewind_reg;
	assign frame_flush = flush_reg;

	// ****************************************
	// manchester encoder
	// ****************************************
	// one bit of latency from the resample; collision sensing uses the same copy
	always_ff @(posedge core_clk) begin
		if (rst) begin
			tx_en_q_reg <= 1'b0;
			tx_dat_q_reg <= 1'b0;
		end else if (bit_en) begin
			tx_en_q_reg <= internal_tx_enable;
			tx_dat_q_reg <= internal_tx_serial_data;
		end
	end

	// outputs are registered from the values that hold in the next cycle
	assign enc_en_ahead = bit_en ? internal_tx_enable : tx_en_q_reg;
	assign enc_dat_ahead = bit_en ? internal_tx_serial_data : tx_dat_q_reg;
	assign enc_half_ahead = ref_en ? ~tx_clk_reg : tx_clk_reg;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			tx_pos <= 1'b0;
			tx_neg <= 1'b0;
		end else begin
			if (enc_en_ahead) begin
				tx_pos <= enc_half_ahead ? enc_dat_ahead : ~enc_dat_ahead;
				tx_neg <= enc_half_ahead ? ~enc_dat_ahead : enc_dat_ahead;
			end else begin
				tx_pos <= tx_idle_select;
				tx_neg <= 1'b0;
			end
		end
	end

	// ****************************************
	// receive carrier and clock acquisition
	// ****************************************
	// short runs are noise; carrier holds for two bit times past the last edge
	assign rx_edge = rx_s2_reg ^ rx_s3_reg;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			rx_run_reg <= '0;
			rx_hold_reg <= '0;
		end else begin
			if (rx_edge)
				rx_run_reg <= '0;
			else if (rx_run_reg != 3'h7)
				rx_run_reg <= rx_run_reg + 3'h1;
			if (rx_edge && (internal_rx_carrier || rx_run_reg >= RX_MIN_PULSE - 3'h1))
				rx_hold_reg <= RX_HOLD_CYC;
			else if (rx_hold_reg != 4'h0)
				rx_hold_reg <= rx_hold_reg - 4'h1;
		end
	end

	assign internal_rx_carrier = rx_hold_reg != 4'h0;

	// bits are taken in the second half-cell on the transmit bit clock
	always_ff @(posedge core_clk) begin
		if (rst || !internal_rx_carrier) begin
			rx_shift_reg <= '0;
			rx_clock_locked <= 1'b0;
			rx_bit <= 1'b0;
			rx_bit_valid <= 1'b0;
		end else begin
			rx_bit_valid <= 1'b0;
			if (bit_en) begin
				rx_shift_reg <= {rx_shift_reg[2:0], rx_s2_reg};
				if ({rx_shift_reg[2:0], rx_s2_reg} == LOCK_PATTERN)
					rx_clock_locked <= 1'b1;
				if (rx_clock_locked) begin
					rx_bit <= rx_s2_reg;
					rx_bit_valid <= 1'b1;
				end
			end
		end
	end

endmodule : mcbm_top

// ---- verif/mcbm_top_asserts.sv ----
// port checks for the collision engine and manchester codec
// assumes binding into mcbm_top, one core clock, synchronous reset
module mcbm_checker (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic tx_in_ready,
	input wire logic frame_rewind,
	input wire logic frame_flush,
	input wire mcbm_pkg::mcbm_status_s tx_status,
	input wire logic tx_idle_select,
	input wire logic tx_pos,
	input wire logic tx_neg,
	input wire logic internal_rx_carrier,
	input wire logic rx_clock_locked,
	input wire logic rx_bit_valid
);
	timeunit 1ns;
	timeprecision 100ps;
	import mcbm_pkg::*;

	// ****************
	// properties
	// ****************
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	// six low cycles on tx_neg cannot happen inside a frame
	a_idle_level: assert property (
		(!tx_neg)[*6] ##0 $stable(tx_idle_select) |-> tx_pos == tx_idle_select)
		else $error("idle level wrong");
	a_pair_opposite: assert property (tx_neg |-> !tx_pos)
		else $error("pair not opposite");
	a_mid_bit_edge: assert property (
		$rose(tx_neg) |-> tx_neg[*2] ##1 (!tx_neg or (tx_neg[*2] ##1 !tx_neg)))
		else $error("half bit length wrong");
	a_ready_clear: assert property ((frame_rewind || frame_flush) |-> !tx_in_ready)
		else $error("ready high while buffer clears");
	a_flush_cause: assert property (
		frame_flush |-> tx_status.done
		&& (tx_status.retry_failure_flag || tx_status.late_collision_flag))
		else $error("flush without cause");
	a_fail_clean: assert property (
		tx_status.retry_failure_flag |-> frame_flush
		&& !tx_status.one_retry && !tx_status.multi_retry)
		else $error("retry failure with counts");
	a_retry_counts: assert property (
		(tx_status.one_retry || tx_status.multi_retry) |-> tx_status.done && !frame_flush
		&& !(tx_status.one_retry && tx_status.multi_retry))
		else $error("retry count flags wrong");
	a_late_final: assert property (
		tx_status.late_collision_flag |-> frame_flush ##1 (!frame_rewind)[*8])
		else $error("late collision retried");
	a_backoff_quiet: assert property (
		frame_rewind |-> !tx_status.done ##6 (!tx_neg)[*8])
		else $error("no gap after rewind");
	a_lock_carrier: assert property ($rose(rx_clock_locked) |-> internal_rx_carrier)
		else $error("lock without carrier");
	a_lock_drop: assert property (
		$fell(internal_rx_carrier) |-> ##[0:1] !rx_clock_locked)
		else $error("lock outlives carrier");
	a_bit_spacing: assert property (rx_bit_valid |=> (!rx_bit_valid)[*3])
		else $error("receive bits too close");
endmodule : mcbm_checker

bind mcbm_top mcbm_checker chk_u (.core_clk, .rst, .tx_in_ready, .frame_rewind, .frame_flush,
	.tx_status, .tx_idle_select, .tx_pos, .tx_neg, .internal_rx_carrier, .rx_clock_locked,
	.rx_bit_valid);

// ---- verif/mcbm_station.sv ----
// model of the other stations sharing the medium
// assumes tx_neg is high only while the block transmits
module mcbm_station (
	input wire logic core_clk,
	input wire logic tx_neg,
	output logic col_pin,
	output logic diff_rx_inputs
);
	timeunit 1ns;
	timeprecision 100ps;
	int col_at = 0;
	int col_left = 0;
	int col_len = 0;
	int quiet = 99;
	int t = 0;
	int hold = 0;
	logic hit = 1'b0;

	initial begin
		col_pin = 1'b0;
		diff_rx_inputs = 1'b0;
	end

	// ****************
	// collisions
	// ****************
	// attempts are told apart by a quiet gap, frames never idle tx_neg that long
	always @(negedge core_clk) begin
		if (tx_neg && quiet > 16) begin
			t = -1;
			hit = 1'b0;
		end
		quiet = tx_neg ? 0 : quiet + 1;
		t++;
		if (quiet == 16 && hit) begin
			col_len = t - 16;
			hit = 1'b0;
		end
		if (hold > 0) begin
			hold--;
		end else if (col_left > 0 && t == col_at && quiet < 16) begin
			hold = 40;
			col_left--;
			hit = 1'b1;
		end
		col_pin = (hold > 0);
	end

	// ****************
	// receive traffic
	// ****************
	task automatic send_bits(input logic [15:0] bits, input int n);
		for (int i = 0; i < n; i++) begin
			repeat (2) @(negedge core_clk) diff_rx_inputs = ~bits[i];
			repeat (2) @(negedge core_clk) diff_rx_inputs = bits[i];
		end
	endtask : send_bits
endmodule : mcbm_station

// ---- verif/mcbm_top_test.sv ----
// self-checking bench for collision handling, backoff and the codec
// assumes the station model supplies collisions and receive traffic
module mcbm_top_test;
	timeunit 1ns;
	timeprecision 100ps;
	import mcbm_pkg::*;
	// fewer attempts keep the retry-failure run short
	localparam int TRIES = 4;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	mcbm_byte_s tx_in = '0;
	logic tx_in_valid = 1'b0;
	logic disable_retry_bit = 1'b0;
	logic tx_idle_select = 1'b0;
	logic alt_backoff_mode = 1'b0;
	logic tx_in_ready, frame_rewind, frame_flush, col_pin, diff_rx_inputs, tx_pos, tx_neg;
	logic internal_rx_carrier, rx_clock_locked, rx_bit, rx_bit_valid;
	mcbm_status_s tx_status;
	logic took = 1'b0;
	logic start = 1'b0;
	logic feeding = 1'b0;
	int fails = 0;
	int samples_checked = 0;
	int fidx = 0;
	int flen = 1;

	always #12.5 core_clk = ~core_clk;

	mcbm_top #(.MAX_TRIES(TRIES)) dut_u (.core_clk, .rst, .tx_in, .tx_in_valid, .tx_in_ready,
		.frame_rewind, .frame_flush, .tx_status, .disable_retry_bit, .tx_idle_select,
		.alt_backoff_mode, .col_pin, .diff_rx_inputs, .tx_pos, .tx_neg, .internal_rx_carrier,
		.rx_clock_locked, .rx_bit, .rx_bit_valid);
	mcbm_station st_u (.core_clk, .tx_neg, .col_pin, .diff_rx_inputs);

	// ****************
	// frame source
	// ****************
	always @(posedge core_clk) took <= tx_in_valid && tx_in_ready;

	// replays from byte 0 on rewind, drops the rest on flush
	always @(negedge core_clk) begin
		if (start) begin
			fidx = 0;
			feeding = 1'b1;
			start = 1'b0;
		end else if (frame_rewind) begin
			fidx = 0;
			feeding = 1'b1;
		end else if (frame_flush) begin
			feeding = 1'b0;
		end else if (took && feeding) begin
			feeding = (fidx != flen - 1);
			fidx++;
		end
		tx_in_valid = feeding;
		tx_in = '{data: 8'(fidx), last: (fidx == flen - 1)};
	end

	// ****************
	// helpers
	// ****************
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic send(input int len, input int at, input int ncol, input logic dis,
		input logic [4:0] exp);
		int n = 0;
		@(negedge core_clk) disable_retry_bit = dis;
		st_u.col_at = at;
		st_u.col_left = ncol;
		flen = len;
		@(posedge core_clk) start = 1'b1;
		@(negedge core_clk);
		while (tx_status.done !== 1'b1 && n < 40000) begin
			@(negedge core_clk);
			n++;
		end
		check(16'(tx_status), 16'(exp));
	endtask : send

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : tally_and_finish

	// ****************
	// scenarios
	// ****************
	task automatic t_idle;
		check(16'({tx_pos, tx_neg}), 16'h0);
		@(negedge core_clk) tx_idle_select = 1'b1;
		repeat (3) @(negedge core_clk);
		check(16'({tx_pos, tx_neg}), 16'h2);
		$display("idle test over");
	endtask : t_idle

	task automatic t_preamble_col;
		send(8, 50, 1, 1'b0, 5'h18);
		// 96 bits of 4 cycles: the full preamble then the jam, with no data sent
		check(16'(st_u.col_len > 377 && st_u.col_len < 391), 16'h1);
		$display("preamble collision test over");
	endtask : t_preamble_col

	task automatic t_data_col;
		send(8, 300, 1, 1'b0, 5'h18);
		check(16'(st_u.col_len > 419 && st_u.col_len < 451), 16'h1);
		$display("data collision test over");
	endtask : t_data_col

	task automatic t_outcomes;
		send(4, 0, 0, 1'b0, 5'h10);
		send(8, 300, 2, 1'b0, 5'h14);
		send(8, 300, TRIES, 1'b0, 5'h12);
		send(8, 300, 1, 1'b1, 5'h12);
		send(70, 2404, 1, 1'b0, 5'h11);
		$display("outcome test over");
	endtask : t_outcomes

	// carrier held during a pending frame: alt mode keeps the finished gap, standard restarts it
	task automatic t_defer(input logic alt, input int lo, input int hi);
		int n = 0;
		@(negedge core_clk) alt_backoff_mode = alt;
		st_u.col_left = 0;
		flen = 2;
		repeat (500) @(negedge core_clk);
		fork
			st_u.send_bits(16'h5555, 16);
		join_none
		repeat (16) @(negedge core_clk);
		check(16'(internal_rx_carrier), 16'h1);
		@(posedge core_clk) start = 1'b1;
		@(negedge core_clk);
		while (internal_rx_carrier !== 1'b0 && n < 200) begin
			@(negedge core_clk);
			n++;
		end
		n = 0;
		while (tx_neg !== 1'b1 && n < 1000) begin
			@(negedge core_clk);
			n++;
		end
		check(16'(n >= lo && n <= hi), 16'h1);
		n = 0;
		while (tx_status.done !== 1'b1 && n < 4000) begin
			@(negedge core_clk);
			n++;
		end
		check(16'(tx_status), 16'h10);
		$display("defer test over");
	endtask : t_defer

	task automatic t_rx;
		logic b0;
		st_u.send_bits(16'h00ff, 8);
		check(16'({internal_rx_carrier, rx_clock_locked}), 16'h2);
		fork
			st_u.send_bits(16'h5555, 16);
		join_none
		repeat (40) @(negedge core_clk);
		check(16'(rx_clock_locked), 16'h1);
		while (rx_bit_valid !== 1'b1) @(negedge core_clk);
		b0 = rx_bit;
		@(negedge core_clk);
		while (rx_bit_valid !== 1'b1) @(negedge core_clk);
		// an alternating line must decode to alternating bits
		check(16'(rx_bit ^ b0), 16'h1);
		repeat (40) @(negedge core_clk);
		check(16'({internal_rx_carrier, rx_clock_locked}), 16'h0);
		$display("receive test over");
	endtask : t_rx

	initial begin
		#(90000 * 25);
		fails++;
		tally_and_finish();
	end

	initial begin
		repeat (5) @(posedge core_clk);
		@(negedge core_clk) rst = 1'b0;
		t_idle();
		t_preamble_col();
		t_data_col();
		t_outcomes();
		t_defer(1'b1, 0, 16);
		t_defer(1'b0, 384, 400);
		t_rx();
		tally_and_finish();
	end
endmodule : mcbm_top_test
